// ---- bpbs_pkg.sv ----
// Purpose: shared constants for the breakpoint and bit set/test decoder
// Assumes: 32-bit datapath, axi4-lite register access
// Notes:   offsets are byte addresses of aligned words
package bpbs_pkg;
    // instruction opcodes seen on the decode port
    localparam logic [3:0] OP_NONE      = 4'h0;
    localparam logic [3:0] OP_BRK_LONG  = 4'h1;
    localparam logic [3:0] OP_BRK_SHORT = 4'h2;
    localparam logic [3:0] OP_SET       = 4'h3;
    localparam logic [3:0] OP_SET_SHORT = 4'h4;
    localparam logic [3:0] OP_TST       = 4'h5;
    localparam logic [3:0] OP_TST_SHORT = 4'h6;
    localparam logic [3:0] OP_FLAG_HALT = 4'h7;
    localparam logic [3:0] OP_OTHER     = 4'h8;
    // register offsets
    localparam logic [7:0] REG_DEBUG    = 8'h00;
    localparam logic [7:0] REG_STATUS   = 8'h04;
    localparam logic [7:0] REG_CTRL     = 8'h08;
    localparam logic [7:0] REG_PC       = 8'h0C;
    localparam logic [7:0] REG_FLAGS    = 8'h10;
    localparam logic [7:0] REG_EVT      = 8'h14;
    localparam logic [7:0] REG_EVT_EN   = 8'h18;
    localparam logic [7:0] REG_EVT_CLR  = 8'h1C;
    // debug register fields
    localparam int DBG_STOPPED = 0;
    localparam int DBG_BSTOP   = 1;
    localparam int DBG_UPERMIT = 2;
    // control register fields
    localparam int CTL_RESTART = 0;
    localparam int CTL_STEP    = 1;
    localparam int CTL_KERNEL  = 2;
    // event bits
    localparam int EVT_BRK     = 0;
    localparam int EVT_PRIV    = 1;
    localparam int EVT_IRQHELD = 2;
    localparam int NUM_EVT     = 3;
    // flag bits in the flag word
    localparam int FLG_Z = 3;
    localparam int FLG_N = 2;
    localparam int FLG_C = 1;
    localparam int FLG_V = 0;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [4:0] BITPOS_MASK = 5'h1F;
endpackage

// ---- bpbs_bitop.sv ----
// Purpose: bit set / bit test datapath
// Assumes: position is the low 5 bits of the second operand, or the immediate for short forms
// Notes:   purely combinational, result is registered by the caller
`timescale 1ns/1ps
module bpbs_bitop (
    input  wire logic [31:0] src1_i,  // first source
    input  wire logic [4:0]  pos_i,   // bit position
    input  wire logic        test_i,  // 1 test (and), 0 set (or)
    output logic      [31:0] res_o,   // result value
    output logic             z_o,     // result zero
    output logic             n_o      // result bit 31
);
    logic [31:0] mask;
    always_comb begin
        mask  = 32'h1 << pos_i;
        res_o = test_i ? (src1_i & mask) : (src1_i | mask);
        z_o   = (res_o == 32'h0);
        n_o   = res_o[31];
    end
endmodule // bpbs_bitop

// ---- bpbs_core.sv ----
// Purpose: breakpoint halt/flush control and bit set/test execution
// Assumes: one opcode per cycle on the decode port, axi4-lite registers
// Notes:   results and flags come out of flip-flops one cycle after issue
`timescale 1ns/1ps
module bpbs_core (
    input  wire logic        ref_clk_i,      // 50 MHz core clock
    input  wire logic        rst_n_i,        // async reset, active low
    input  wire logic [3:0]  op_i,           // decoded opcode in stage 1
    input  wire logic [31:0] op_pc_i,        // address of that instruction
    input  wire logic        op_cc_i,        // condition code true
    input  wire logic        op_f_i,         // set-flags suffix
    input  wire logic [31:0] src1_i,         // first source
    input  wire logic [31:0] src2_i,         // second source
    input  wire logic [4:0]  imm5_i,         // short-form immediate
    input  wire logic        older_busy_i,   // older instructions in flight
    input  wire logic        irq_req_i,      // interrupt request
    output logic             issue_en_o,     // may accept next instruction
    output logic             flush_o,        // pipeline flush pulse
    output logic             irq_take_o,     // interrupt accepted
    output logic             priv_exc_o,     // privilege violation pulse
    output logic             wb_en_o,        // destination write
    output logic [31:0]      wb_data_o,      // destination value
    output logic             irq_o,          // level interrupt
    input  wire logic [7:0]  s_axi_awaddr,   // write address
    input  wire logic        s_axi_awvalid,  // write address valid
    output logic             s_axi_awready,  // write address ready
    input  wire logic [31:0] s_axi_wdata,    // write data
    input  wire logic [3:0]  s_axi_wstrb,    // write strobes
    input  wire logic        s_axi_wvalid,   // write data valid
    output logic             s_axi_wready,   // write data ready
    output logic [1:0]       s_axi_bresp,    // write response
    output logic             s_axi_bvalid,   // write response valid
    input  wire logic        s_axi_bready,   // write response ready
    input  wire logic [7:0]  s_axi_araddr,   // read address
    input  wire logic        s_axi_arvalid,  // read address valid
    output logic             s_axi_arready,  // read address ready
    output logic [31:0]      s_axi_rdata,    // read data
    output logic [1:0]       s_axi_rresp,    // read response
    output logic             s_axi_rvalid,   // read data valid
    input  wire logic        s_axi_rready    // read data ready
);
    typedef enum logic [2:0] {
        BPBS_RUN   = 3'b001,
        BPBS_DRAIN = 3'b010,
        BPBS_HALT  = 3'b100
    } bpbs_mode_e;

    typedef struct packed {
        bpbs_mode_e  mode;
        logic        stopped;
        logic        bstop;
        logic        upermit;
        logic        kernel;
        logic        step;
        logic [31:0] pc;
        logic [3:0]  flags;
        logic [2:0]  evt;
        logic [2:0]  evt_en;
        logic        flush;
        logic        priv;
        logic        wb_en;
        logic [31:0] wb_data;
        logic        aw_got;
        logic        w_got;
        logic [7:0]  awaddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } bpbs_state_s;

    bpbs_state_s st;
    bpbs_state_s next_st;
    logic [1:0]  rst_sync;
    logic        rst_n;

    // reset is released through two flops; assertion stays asynchronous
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    logic        is_brk;
    logic        is_set;
    logic        is_tst;
    logic        brk_ok;
    logic [4:0]  pos;
    logic [31:0] bo_res;
    logic        bo_z;
    logic        bo_n;
    logic        wr_fire;
    logic        go;

    assign is_brk = (op_i == bpbs_pkg::OP_BRK_LONG) || (op_i == bpbs_pkg::OP_BRK_SHORT);
    assign is_set = (op_i == bpbs_pkg::OP_SET) || (op_i == bpbs_pkg::OP_SET_SHORT);
    assign is_tst = (op_i == bpbs_pkg::OP_TST) || (op_i == bpbs_pkg::OP_TST_SHORT);
    assign brk_ok = st.kernel || st.upermit;
    // short forms use the immediate, long forms the second source
    assign pos = ((op_i == bpbs_pkg::OP_SET_SHORT) || (op_i == bpbs_pkg::OP_TST_SHORT))
               ? imm5_i : (src2_i[4:0] & bpbs_pkg::BITPOS_MASK);
    // only the run state issues; a single step lets one instruction through
    assign go = (st.mode == BPBS_RUN);

    bpbs_bitop u_bitop (
        .src1_i (src1_i),
        .pos_i  (pos),
        .test_i (is_tst),
        .res_o  (bo_res),
        .z_o    (bo_z),
        .n_o    (bo_n)
    );

    assign wr_fire = st.aw_got && st.w_got && !st.bvalid;

    always_comb begin
        logic [31:0] wmask;
        logic        clr_halt;
        logic        brk_evt;
        logic        priv_evt;
        logic        irq_held;
        wmask    = 32'h0;
        clr_halt = 1'b0;
        brk_evt  = 1'b0;
        priv_evt = 1'b0;
        irq_held = 1'b0;
        next_st         = st;
        next_st.flush   = 1'b0;
        next_st.priv    = 1'b0;
        next_st.wb_en   = 1'b0;

        // instruction side
        if (go && op_i != bpbs_pkg::OP_NONE) begin
            next_st.pc = op_pc_i;
            if (st.step) begin
                next_st.mode = BPBS_HALT;
                next_st.stopped = 1'b1;
                next_st.step = 1'b0;
            end
            if (op_i == bpbs_pkg::OP_FLAG_HALT) begin
                // halt write finishes and flushes before anything behind it
                next_st.mode    = BPBS_HALT;
                next_st.stopped = 1'b1;
                next_st.flush   = 1'b1;
            end else if (is_brk && brk_ok) begin
                // any slot works: the stop is taken in stage 1 regardless
                next_st.mode  = older_busy_i ? BPBS_DRAIN : BPBS_HALT;
                next_st.flush = 1'b1;
                next_st.bstop = 1'b1;
                next_st.stopped = 1'b1;
                brk_evt = 1'b1;
                irq_held = irq_req_i;
            end else if (is_brk) begin
                next_st.priv = 1'b1;
                next_st.flush = 1'b1;
                priv_evt = 1'b1;
            end else if (is_set && op_cc_i) begin
                next_st.wb_en   = 1'b1;
                next_st.wb_data = bo_res;
                if (op_f_i) begin
                    next_st.flags[bpbs_pkg::FLG_Z] = bo_z;
                    next_st.flags[bpbs_pkg::FLG_N] = bo_n;
                end
            end else if (is_tst && op_cc_i) begin
                // no destination write, flags always
                next_st.flags[bpbs_pkg::FLG_Z] = bo_z;
                next_st.flags[bpbs_pkg::FLG_N] = bo_n;
            end
        end
        if (st.mode == BPBS_DRAIN && !older_busy_i) begin
            next_st.mode = BPBS_HALT;
        end

        // register writes
        if (s_axi_awvalid && !st.aw_got) begin
            next_st.aw_got = 1'b1;
            next_st.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st.w_got) begin
            next_st.w_got = 1'b1;
            next_st.wdata = s_axi_wdata;
            next_st.wstrb = s_axi_wstrb;
        end
        if (wr_fire) begin
            for (int i = 0; i < 4; i++) begin
                wmask[i*8 +: 8] = {8{st.wstrb[i]}};
            end
            next_st.aw_got = 1'b0;
            next_st.w_got  = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp  = bpbs_pkg::RESP_OKAY;
            unique case ({st.awaddr[7:2], 2'h0})
                bpbs_pkg::REG_DEBUG: begin
                    if (wmask[bpbs_pkg::DBG_UPERMIT]) begin
                        next_st.upermit = st.wdata[bpbs_pkg::DBG_UPERMIT];
                    end
                end
                bpbs_pkg::REG_CTRL: begin
                    if (wmask[0]) begin
                        clr_halt = st.wdata[bpbs_pkg::CTL_RESTART] | st.wdata[bpbs_pkg::CTL_STEP];
                        next_st.step = st.wdata[bpbs_pkg::CTL_STEP];
                        next_st.kernel = st.wdata[bpbs_pkg::CTL_KERNEL];
                    end
                end
                bpbs_pkg::REG_PC: begin
                    // pc rewrite from the debugger only lands in the halt state; resume does not flush or refetch
                    if (st.mode == BPBS_HALT) begin
                        next_st.pc = (st.pc & ~wmask) | (st.wdata & wmask);
                    end
                end
                bpbs_pkg::REG_EVT_EN: begin
                    if (wmask[0]) begin
                        next_st.evt_en = st.wdata[2:0];
                    end
                end
                bpbs_pkg::REG_EVT_CLR: begin
                    if (wmask[0]) begin
                        next_st.evt = st.evt & ~st.wdata[2:0];
                    end
                end
                bpbs_pkg::REG_STATUS, bpbs_pkg::REG_FLAGS, bpbs_pkg::REG_EVT: begin
                end
                default: begin
                    next_st.bresp = bpbs_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (clr_halt && st.mode == BPBS_HALT) begin
            next_st.mode    = BPBS_RUN;
            next_st.stopped = 1'b0;
            next_st.bstop   = 1'b0;
        end
        // set wins over clear for the sticky events
        next_st.evt = next_st.evt | {irq_held, priv_evt, brk_evt};
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end

        // register reads
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !st.rvalid) begin
            next_st.rvalid = 1'b1;
            next_st.rresp  = bpbs_pkg::RESP_OKAY;
            next_st.rdata  = 32'h0;
            unique case ({s_axi_araddr[7:2], 2'h0})
                bpbs_pkg::REG_DEBUG: begin
                    next_st.rdata[bpbs_pkg::DBG_STOPPED] = st.stopped;
                    next_st.rdata[bpbs_pkg::DBG_BSTOP]   = st.bstop;
                    next_st.rdata[bpbs_pkg::DBG_UPERMIT] = st.upermit;
                end
                bpbs_pkg::REG_STATUS: next_st.rdata[2:0] = st.mode;
                bpbs_pkg::REG_CTRL:   next_st.rdata[bpbs_pkg::CTL_KERNEL] = st.kernel;
                bpbs_pkg::REG_PC:     next_st.rdata = st.pc;
                bpbs_pkg::REG_FLAGS:  next_st.rdata[3:0] = st.flags;
                bpbs_pkg::REG_EVT:    next_st.rdata[2:0] = st.evt;
                bpbs_pkg::REG_EVT_EN: next_st.rdata[2:0] = st.evt_en;
                bpbs_pkg::REG_EVT_CLR: begin
                end
                default: next_st.rresp = bpbs_pkg::RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            st        <= '0;
            st.mode   <= BPBS_RUN;
            st.kernel <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // issue stops the same cycle a breakpoint is seen, not one later
    assign issue_en_o    = go && !(is_brk && brk_ok) && op_i != bpbs_pkg::OP_FLAG_HALT;
    assign irq_take_o    = go && irq_req_i && !(is_brk && brk_ok);
    assign flush_o       = st.flush;
    assign priv_exc_o    = st.priv;
    assign wb_en_o       = st.wb_en;
    assign wb_data_o     = st.wb_data;
    assign irq_o         = |(st.evt & st.evt_en);
    assign s_axi_awready = !st.aw_got;
    assign s_axi_wready  = !st.w_got;
    assign s_axi_bvalid  = st.bvalid;
    assign s_axi_bresp   = st.bresp;
    assign s_axi_arready = !st.rvalid;
    assign s_axi_rvalid  = st.rvalid;
    assign s_axi_rdata   = st.rdata;
    assign s_axi_rresp   = st.rresp;

    // single-bit view of the tested operand, kept apart from the bit-op datapath
    logic        tst_hit;
    assign tst_hit = src1_i[pos];

    sequence brk_seen_q;
        go && is_brk && brk_ok;
    endsequence
    sequence halted_q;
        st.stopped && st.bstop;
    endsequence

    brk_halt_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        brk_seen_q |=> halted_q) else $error("breakpoint did not set stop bits");
    brk_flush_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        brk_seen_q |=> flush_o) else $error("breakpoint did not flush");
    brk_noissue_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        brk_seen_q |-> !issue_en_o ##1 !issue_en_o) else $error("issue after breakpoint");
    brk_flags_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        brk_seen_q |=> st.flags == $past(st.flags)) else $error("breakpoint changed flags");
    irq_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        brk_seen_q |-> !irq_take_o) else $error("interrupt taken with breakpoint");
    brk_priv_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        go && is_brk && !brk_ok |=> priv_exc_o && !st.bstop) else $error("no privilege trap");
    brk_pc_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        brk_seen_q |=> st.pc == $past(op_pc_i)) else $error("halt pc is not breakpoint");
    bstop_clr_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        $fell(st.stopped) |-> !st.bstop) else $error("stop indicator survived restart");
    set_wb_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        go && is_set && op_cc_i |=> wb_en_o && wb_data_o[$past(pos)]) else $error("bit not set");
    tst_nowb_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        go && is_tst |=> !wb_en_o) else $error("bit test wrote a register");
    tst_flag_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        go && is_tst && op_cc_i |=> st.flags[bpbs_pkg::FLG_Z] == !$past(tst_hit))
        else $error("test zero flag wrong");
    set_nof_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        go && is_set && !op_f_i |=> $stable(st.flags)) else $error("flags changed no suffix");
endmodule // bpbs_core

// ---- bpbs_dbg_host.sv ----
// Purpose: debugger host model on the axi4-lite register port
// Assumes: one clock, one write and one read at a time
// Notes:   released payload is inverted so stale values are never trusted
`timescale 1ns/1ps
module bpbs_dbg_host (
    input  wire logic        clk_i,    // core clock
    output logic [7:0]       awaddr,   // write address
    output logic             awvalid,  // aw valid
    input  wire logic        awready,  // aw ready
    output logic [31:0]      wdata,    // write data
    output logic [3:0]       wstrb,    // strobes
    output logic             wvalid,   // w valid
    input  wire logic        wready,   // w ready
    input  wire logic [1:0]  bresp,    // write resp
    input  wire logic        bvalid,   // b valid
    output logic             bready,   // b ready
    output logic [7:0]       araddr,   // read address
    output logic             arvalid,  // ar valid
    input  wire logic        arready,  // ar ready
    input  wire logic [31:0] rdata,    // read data
    input  wire logic [1:0]  rresp,    // read resp
    input  wire logic        rvalid,   // r valid
    output logic             rready    // r ready
);
    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk_i);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= 4'hF;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        forever begin
            @(posedge clk_i);
            if (awvalid && awready) begin
                awvalid <= 1'b0;
                awaddr  <= ~awaddr;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
                wdata  <= ~wdata;
            end
            if (bvalid) break;
        end
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_i);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        forever begin
            @(posedge clk_i);
            if (arvalid && arready) begin
                arvalid <= 1'b0;
                araddr  <= ~araddr;
            end
            if (rvalid) break;
        end
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    // code restore and line invalidate live outside this block; resume rewrites the pc, then writes restart with kernel set
    task automatic resume(input logic [31:0] pc, output logic [1:0] r);
        wr(bpbs_pkg::REG_PC, pc, r);
        wr(bpbs_pkg::REG_CTRL, 32'h5, r);
    endtask
endmodule // bpbs_dbg_host

// ---- bpbs_core_tb.sv ----
// Purpose: self-checking bench for breakpoint halt and bit set/test
// Assumes: host model speaks axi4-lite
// Notes:   expectations follow documented behaviour only
`timescale 1ns/1ps
module bpbs_core_tb;
    logic        ref_clk, rst_n, cc, fs, busy, irq_req, iss, flush, take, priv, wb_en, irq;
    logic [3:0]  op, wstrb;
    logic [4:0]  imm;
    logic [31:0] pc, s1, s2, wb_data, rv, wdata, rdata;
    logic [1:0]  rsp, bresp, rresp;
    logic [7:0]  awaddr, araddr;
    logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    int          failures, checked;
    bpbs_core uut (
        .ref_clk_i(ref_clk), .rst_n_i(rst_n), .op_i(op), .op_pc_i(pc), .op_cc_i(cc),
        .op_f_i(fs), .src1_i(s1), .src2_i(s2), .imm5_i(imm), .older_busy_i(busy),
        .irq_req_i(irq_req), .issue_en_o(iss), .flush_o(flush), .irq_take_o(take),
        .priv_exc_o(priv), .wb_en_o(wb_en), .wb_data_o(wb_data), .irq_o(irq),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready)
    );
    bpbs_dbg_host host (
        .clk_i(ref_clk), .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready
    );
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        host.wr(a, d, rsp);
        chk({30'h0, rsp}, {30'h0, bpbs_pkg::RESP_OKAY});
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        host.rd(a, rv, rsp);
        chk({30'h0, rsp}, {30'h0, bpbs_pkg::RESP_OKAY});
        chk(rv, exp);
    endtask
    task automatic put(input logic [3:0] o, input logic [31:0] p, input logic c, input logic f,
                       input logic [31:0] a, input logic [31:0] b, input logic [4:0] i,
                       input logic q);
        @(posedge ref_clk);
        op      <= o;
        pc      <= p;
        cc      <= c;
        fs      <= f;
        s1      <= a;
        s2      <= b;
        imm     <= i;
        irq_req <= q;
        #1;
    endtask
    // one instruction, then an idle slot so the registered results can be seen
    task automatic issue(input logic [3:0] o, input logic [31:0] a, input logic [31:0] b,
                         input logic [4:0] i, input logic c, input logic f);
        put(o, 32'h100, c, f, a, b, i, 1'b0);
        put(bpbs_pkg::OP_NONE, 32'h0, 1'b0, 1'b0, 32'h0, 32'h0, 5'h00, 1'b0);
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // whole run is under two hundred cycles
    initial begin
        repeat (5000) @(posedge ref_clk);
        failures++;
        stop_test();
    end
    initial begin
        failures = 0;
        checked  = 0;
        rst_n    = 1'b0;
        busy     = 1'b0;
        {op, pc, cc, fs, s1, s2, imm, irq_req} = '0;
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rchk(bpbs_pkg::REG_DEBUG, 32'h0);
        rchk(bpbs_pkg::REG_STATUS, 32'h1);
        host.rd(8'h20, rv, rsp);
        chk({30'h0, rsp}, {30'h0, bpbs_pkg::RESP_SLVERR});
        put(bpbs_pkg::OP_NONE, 32'h0, 1'b0, 1'b0, 32'h0, 32'h0, 5'h00, 1'b1);
        chk({31'h0, iss}, 32'h1);
        chk({31'h0, take}, 32'h1);
        issue(bpbs_pkg::OP_SET, 32'h0, 32'hFF, 5'h00, 1'b1, 1'b1);
        chk({31'h0, wb_en}, 32'h1);
        chk(wb_data, 32'h8000_0000);
        rchk(bpbs_pkg::REG_FLAGS, 32'h4);
        issue(bpbs_pkg::OP_SET_SHORT, 32'h10, 32'h0, 5'h05, 1'b1, 1'b0);
        chk(wb_data, 32'h30);
        rchk(bpbs_pkg::REG_FLAGS, 32'h4);
        issue(bpbs_pkg::OP_SET, 32'h0, 32'h1, 5'h00, 1'b0, 1'b1);
        chk({31'h0, wb_en}, 32'h0);
        issue(bpbs_pkg::OP_TST, 32'h1, 32'h21, 5'h00, 1'b1, 1'b0);
        chk({31'h0, wb_en}, 32'h0);
        rchk(bpbs_pkg::REG_FLAGS, 32'h8);
        issue(bpbs_pkg::OP_TST_SHORT, 32'h8000_0000, 32'h0, 5'h1F, 1'b1, 1'b0);
        rchk(bpbs_pkg::REG_FLAGS, 32'h4);
        issue(bpbs_pkg::OP_TST, 32'h0, 32'h0, 5'h00, 1'b0, 1'b1);
        rchk(bpbs_pkg::REG_FLAGS, 32'h4);
        wreg(bpbs_pkg::REG_CTRL, 32'h0);
        issue(bpbs_pkg::OP_BRK_LONG, 32'h0, 32'h0, 5'h00, 1'b1, 1'b0);
        chk({31'h0, priv}, 32'h1);
        rchk(bpbs_pkg::REG_DEBUG, 32'h0);
        rchk(bpbs_pkg::REG_EVT, 32'h2);
        wreg(bpbs_pkg::REG_EVT_EN, 32'h2);
        @(posedge ref_clk);
        #1;
        chk({31'h0, irq}, 32'h1);
        wreg(bpbs_pkg::REG_EVT_EN, 32'h0);
        @(posedge ref_clk);
        #1;
        chk({31'h0, irq}, 32'h0);
        wreg(bpbs_pkg::REG_EVT_CLR, 32'h2);
        rchk(bpbs_pkg::REG_EVT, 32'h0);
        wreg(bpbs_pkg::REG_DEBUG, 32'h4);
        busy <= 1'b1;
        put(bpbs_pkg::OP_BRK_SHORT, 32'h200, 1'b1, 1'b0, 32'h0, 32'h0, 5'h00, 1'b1);
        chk({31'h0, iss}, 32'h0);
        chk({31'h0, take}, 32'h0);
        put(bpbs_pkg::OP_NONE, 32'h0, 1'b0, 1'b0, 32'h0, 32'h0, 5'h00, 1'b0);
        chk({31'h0, flush}, 32'h1);
        rchk(bpbs_pkg::REG_STATUS, 32'h2);
        busy <= 1'b0;
        rchk(bpbs_pkg::REG_STATUS, 32'h4);
        rchk(bpbs_pkg::REG_DEBUG, 32'h7);
        rchk(bpbs_pkg::REG_PC, 32'h200);
        rchk(bpbs_pkg::REG_FLAGS, 32'h4);
        rchk(bpbs_pkg::REG_EVT, 32'h5);
        chk({31'h0, iss}, 32'h0);
        host.resume(32'h200, rsp);
        chk({30'h0, rsp}, {30'h0, bpbs_pkg::RESP_OKAY});
        rchk(bpbs_pkg::REG_DEBUG, 32'h4);
        rchk(bpbs_pkg::REG_STATUS, 32'h1);
        put(bpbs_pkg::OP_FLAG_HALT, 32'h300, 1'b1, 1'b0, 32'h0, 32'h0, 5'h00, 1'b0);
        put(bpbs_pkg::OP_BRK_LONG, 32'h304, 1'b1, 1'b0, 32'h0, 32'h0, 5'h00, 1'b0);
        put(bpbs_pkg::OP_NONE, 32'h0, 1'b0, 1'b0, 32'h0, 32'h0, 5'h00, 1'b0);
        rchk(bpbs_pkg::REG_DEBUG, 32'h5);
        rchk(bpbs_pkg::REG_STATUS, 32'h4);
        host.resume(32'h300, rsp);
        issue(bpbs_pkg::OP_BRK_LONG, 32'h0, 32'h0, 5'h00, 1'b1, 1'b0);
        rchk(bpbs_pkg::REG_DEBUG, 32'h7);
        rchk(bpbs_pkg::REG_PC, 32'h100);
        wreg(bpbs_pkg::REG_CTRL, 32'h6);
        rchk(bpbs_pkg::REG_DEBUG, 32'h4);
        issue(bpbs_pkg::OP_SET, 32'h0, 32'h0, 5'h00, 1'b1, 1'b0);
        rchk(bpbs_pkg::REG_STATUS, 32'h4);
        rchk(bpbs_pkg::REG_DEBUG, 32'h5);
        stop_test();
    end
endmodule // bpbs_core_tb
